// ===== design/aoc_regs.sv
/*
  Average over-current response and limit command registers, with the
  averaging filter, sticky fault status and the response sequencer.
  Assumes a PMBus transaction layer on core_clk_i presenting decoded
  commands, and a current telemetry stream with its own sample clock.
*/
// Functional notes
// - floor rating word reads fixed 0x0100
// - ceiling rating word reads fixed 0x0b01
// - identity: block read, count one, id high
// - revision: block read, count one, rev high
// - fault sets status bits and alert
// - fault bit stays set after condition
// - reaction resets 0x80, storable to nvm
// - mode 00 continue, hold current limit
// - mode 01 continue unless undervoltage
// - mode 10 limit for delay, then retry if still limiting, else run on
// - mode 11 shut down, then retry
// - retry 000 stays off until cleared
// - retry 111 hiccups every second; in modes 10 and 11 the code hiccups once per new fault, then runs on
// - unsupported retry write flags invalid data
// - delay code picks window length
// - limit word resets 0xe340, storable
// - exponent read-only, wrong one flags invalid
// - zero amp limit not allowed, no max
// - fault when average reaches limit
// - percent word holds three threshold fields
// - percent word resets 0x06e0, storable
// - latched bits clear only by defined means
`default_nettype none

module aoc_regs
  import aoc_pkg::*;
#(
  parameter logic [7:0] SI_ID = 8'h5a,     // arbitrary identity value
  parameter logic [7:0] SI_REV = 8'h01,    // arbitrary revision value
  parameter int D0_CYC = (DELAY_NS[0] + CLK_NS - 1) / CLK_NS,
  parameter int D1_CYC = (DELAY_NS[1] + CLK_NS - 1) / CLK_NS,
  parameter int D2_CYC = (DELAY_NS[2] + CLK_NS - 1) / CLK_NS,
  parameter int D3_CYC = (DELAY_NS[3] + CLK_NS - 1) / CLK_NS,
  parameter int D4_CYC = (DELAY_NS[4] + CLK_NS - 1) / CLK_NS,
  parameter int D5_CYC = (DELAY_NS[5] + CLK_NS - 1) / CLK_NS,
  parameter int D6_CYC = (DELAY_NS[6] + CLK_NS - 1) / CLK_NS,
  parameter int D7_CYC = (DELAY_NS[7] + CLK_NS - 1) / CLK_NS,
  parameter int HICCUP_CYCLES = HICCUP_CYC
) (
  input wire logic core_clk_i,            // 50 MHz core clock
  input wire logic rst_i,                 // sync reset, bias power loss
  input wire logic cmd_valid_i,           // one-cycle command strobe
  input wire logic cmd_write_i,           // 1 write, 0 read
  input wire logic cmd_block_i,           // block protocol used
  input wire logic [7:0] cmd_code_i,      // command code
  input wire logic [15:0] cmd_wdata_i,    // write word
  input wire logic clear_faults_i,        // clear-faults pulse
  input wire logic clear_avg_bit_i,       // individual bit clear pulse
  input wire logic store_all_i,           // store-all-user pulse
  input wire logic sample_clk_i,          // telemetry sample clock pin
  input wire logic [10:0] iout_mant_i,    // output current, 62.5 mA lsb
  input wire logic output_enable_i,       // commanded on (pin/command)
  input wire logic output_undervoltage_condition_i, // uv pin
  input wire logic limiting_i,            // stage is in current limit
  output var logic rsp_valid_o,           // answer strobe
  output var logic [15:0] rsp_data_o,     // read word
  output var logic rsp_nack_o,            // command refused
  output var logic invalid_data_o,        // invalid data fault pulse
  output var aoc_status_t status_o,       // sticky status bits
  output var logic host_alert_output_n_o, // alert, low active
  output var logic current_limit_o,       // hold at oc limit
  output var logic output_off_o,          // power stage disabled
  output var logic nvm_store_o,           // nvm write pulse
  output var aoc_nvm_image_t nvm_image_o, // image to store
  output var aoc_pct_t pct_o,             // live voltage thresholds
  output var logic [15:0] avg_current_o   // averaged current word
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins;

  aoc_sync #(.W(4)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i({sample_clk_i, output_enable_i,
          output_undervoltage_condition_i, limiting_i}),
    .q_o(pins)
  );

  wire logic smp_lvl = pins[3];
  wire logic en_lvl = pins[2];
  wire logic uv_lvl = pins[1];
  wire logic lim_lvl = pins[0];

  logic smp_d;
  logic en_d;

  wire logic smp_rise = smp_lvl & ~smp_d;
  wire logic en_rise = en_lvl & ~en_d;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  aoc_reaction_t reaction;
  logic [15:0] threshold;
  aoc_pct_t pct;

  wire logic is_write = cmd_valid_i & cmd_write_i;
  wire logic is_read = cmd_valid_i & ~cmd_write_i;
  wire aoc_reaction_t wr_reaction = aoc_reaction_t'(cmd_wdata_i[7:0]);
  wire logic [4:0] wr_exp = cmd_wdata_i[15:EXP_LSB];
  wire logic [10:0] wr_mant = cmd_wdata_i[EXP_LSB-1:0];

  // only latch and hiccup retry codes
  wire logic reaction_bad = (wr_reaction.retry != RETRY_LATCH) &&
                            (wr_reaction.retry != RETRY_HICCUP);
  wire logic threshold_bad = (wr_exp != CURRENT_EXP) ||
                             (wr_mant == 11'h000);

  wire logic wr_reaction_hit = is_write && !cmd_block_i &&
                               cmd_code_i == CMD_AVG_REACTION;
  wire logic wr_threshold_hit = is_write && !cmd_block_i &&
                                cmd_code_i == CMD_AVG_THRESHOLD;
  wire logic wr_pct_hit = is_write && !cmd_block_i &&
                          cmd_code_i == CMD_PCT_THRESHOLDS;

  wire logic next_invalid = (wr_reaction_hit && reaction_bad) ||
                            (wr_threshold_hit && threshold_bad);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reaction <= aoc_reaction_t'(REACTION_RST);
      threshold <= THRESHOLD_RST;
      pct <= aoc_pct_t'(PCT_RST);
    end else begin
      if (wr_reaction_hit && !reaction_bad) begin
        reaction <= wr_reaction;
      end
      // exponent fixed, mantissa only, no max check
      if (wr_threshold_hit && !threshold_bad) begin
        threshold <= {CURRENT_EXP, wr_mant};
      end
      // field ordering is the host's duty, stored as written
      if (wr_pct_hit) begin
        pct <= aoc_pct_t'(cmd_wdata_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic [15:0] rd_word;
  logic rd_ok;

  always_comb begin
    rd_word = 16'h0000;
    rd_ok = 1'b1;
    case (cmd_code_i)
      CMD_RATED_FLOOR: rd_word = RATED_FLOOR_VAL;
      CMD_RATED_CEIL: rd_word = RATED_CEIL_VAL;
      CMD_SI_IDENTITY: begin
        rd_word = {SI_ID, BLOCK_COUNT_ONE};
        rd_ok = cmd_block_i;
      end
      CMD_SI_REVISION: begin
        rd_word = {SI_REV, BLOCK_COUNT_ONE};
        rd_ok = cmd_block_i;
      end
      CMD_AVG_REACTION: rd_word = {8'h00, reaction};
      CMD_AVG_THRESHOLD: rd_word = threshold;
      CMD_PCT_THRESHOLDS: rd_word = pct;
      default: rd_ok = 1'b0;
    endcase
    // block framing only for the block codes
    if (cmd_code_i != CMD_SI_IDENTITY && cmd_code_i != CMD_SI_REVISION &&
        cmd_block_i) begin
      rd_ok = 1'b0;
    end
  end

  wire logic wr_ok = wr_reaction_hit || wr_threshold_hit || wr_pct_hit;
  wire logic next_nack = is_read ? !rd_ok : (is_write && !wr_ok);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
      rsp_nack_o <= 1'b0;
      invalid_data_o <= 1'b0;
    end else begin
      rsp_valid_o <= cmd_valid_i;
      rsp_data_o <= (is_read && rd_ok) ? rd_word : 16'h0000;
      rsp_nack_o <= cmd_valid_i && next_nack;
      invalid_data_o <= next_invalid;
    end
  end

  // ----------------------------------------------------------------
  // nvm image
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      nvm_store_o <= 1'b0;
      nvm_image_o <= '0;
    end else begin
      nvm_store_o <= store_all_i;
      if (store_all_i) begin
        nvm_image_o <= {reaction, threshold, pct};
      end
    end
  end

  // ----------------------------------------------------------------
  // averaging: mean of the last block of sixteen samples
  // ----------------------------------------------------------------
  logic [10+AVG_LOG2:0] acc;
  logic [AVG_LOG2-1:0] smp_cnt;
  logic [10:0] avg_mant;

  wire logic [10+AVG_LOG2:0] acc_sum = acc + {{AVG_LOG2{1'b0}}, iout_mant_i};
  wire logic last_smp = smp_cnt == 4'(AVG_SAMPLES - 1);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      smp_d <= 1'b0;
      en_d <= 1'b0;
      acc <= '0;
      smp_cnt <= '0;
      avg_mant <= 11'h000;
    end else begin
      smp_d <= smp_lvl;
      en_d <= en_lvl;
      // data settle well before the edge
      if (smp_rise) begin
        smp_cnt <= smp_cnt + 4'h1;
        acc <= last_smp ? '0 : acc_sum;
        if (last_smp) begin
          avg_mant <= acc_sum[10+AVG_LOG2:AVG_LOG2];
        end
      end
    end
  end

  wire logic over_avg = avg_mant >= threshold[10:0];

  // ----------------------------------------------------------------
  // sticky fault bit
  // ----------------------------------------------------------------
  logic fault;

  // re-enable clears; bias loss is reset
  wire logic clr_req = clear_faults_i | clear_avg_bit_i | en_rise;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fault <= 1'b0;
    end else if (over_avg) begin
      fault <= 1'b1;
    end else if (clr_req) begin
      fault <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      host_alert_output_n_o <= 1'b1;
    end else begin
      status_o <= '{status_iout: fault, status_none: fault,
                    mfr_avg_bit7: fault};
      host_alert_output_n_o <= ~fault;
    end
  end

  // ----------------------------------------------------------------
  // response sequencer
  // ----------------------------------------------------------------
  aoc_state_t state;
  aoc_state_t next_state;
  logic [25:0] tmr;
  logic fault_d;

  wire logic fault_new = fault & ~fault_d;
  logic [25:0] delay_cyc;

  always_comb begin
    case (reaction.delay)
      3'h0: delay_cyc = 26'(D0_CYC);
      3'h1: delay_cyc = 26'(D1_CYC);
      3'h2: delay_cyc = 26'(D2_CYC);
      3'h3: delay_cyc = 26'(D3_CYC);
      3'h4: delay_cyc = 26'(D4_CYC);
      3'h5: delay_cyc = 26'(D5_CYC);
      3'h6: delay_cyc = 26'(D6_CYC);
      default: delay_cyc = 26'(D7_CYC);
    endcase
  end

  wire logic tmr_done = tmr == 26'h0000000;
  wire aoc_state_t retry_state = (reaction.retry == RETRY_HICCUP) ?
                                 ST_HICCUP : ST_LATCHED;

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (fault_new) begin
          case (reaction.mode)
            2'b00: next_state = ST_RUN;
            2'b01: next_state = ST_RUN;
            2'b10: next_state = ST_LIMIT;
            default: next_state = retry_state;
          endcase
        end else if (reaction.mode == 2'b01 && fault && uv_lvl) begin
          next_state = retry_state;
        end
      end
      ST_LIMIT: begin
        if (tmr_done) begin
          next_state = lim_lvl ? retry_state : ST_RUN;
        end
      end
      ST_LATCHED: begin
        if (!fault) begin
          next_state = ST_RUN;
        end
      end
      ST_HICCUP: begin
        if (tmr_done) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
    // commanded off ends any sequence
    if (!en_lvl) begin
      next_state = ST_OFF;
    end else if (state == ST_OFF) begin
      next_state = ST_RUN;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ST_OFF;
      tmr <= 26'h0000000;
      fault_d <= 1'b0;
    end else begin
      state <= next_state;
      fault_d <= fault;
      if (next_state == ST_LIMIT && state != ST_LIMIT) begin
        tmr <= delay_cyc - 26'h0000001;
      end else if (next_state == ST_HICCUP && state != ST_HICCUP) begin
        tmr <= 26'(HICCUP_CYCLES - 1);
      end else if (!tmr_done) begin
        tmr <= tmr - 26'h0000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs to the power stage
  // ----------------------------------------------------------------
  // levels for the power stage
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      current_limit_o <= 1'b0;
      output_off_o <= 1'b1;
      pct_o <= aoc_pct_t'(PCT_RST);
      avg_current_o <= 16'h0000;
    end else begin
      current_limit_o <= (next_state == ST_LIMIT) ||
                         (next_state == ST_RUN && over_avg &&
                          (reaction.mode == 2'b00 ||
                           reaction.mode == 2'b01));
      output_off_o <= (next_state == ST_LATCHED) ||
                      (next_state == ST_HICCUP) ||
                      (next_state == ST_OFF);
      pct_o <= pct;
      avg_current_o <= {CURRENT_EXP, avg_mant};
    end
  end

endmodule

`default_nettype wire

// ===== design/aoc_pkg.sv
/*
  Constants, field layouts and carrier types for the average
  over-current and limit command registers.
  Assumes a 50 MHz core clock and a PMBus transaction layer outside.
*/
`default_nettype none

package aoc_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RATED_FLOOR = 8'ha4;
  localparam logic [7:0] CMD_RATED_CEIL = 8'ha5;
  localparam logic [7:0] CMD_SI_IDENTITY = 8'had;
  localparam logic [7:0] CMD_SI_REVISION = 8'hae;
  localparam logic [7:0] CMD_AVG_REACTION = 8'hc4;
  localparam logic [7:0] CMD_AVG_THRESHOLD = 8'hc5;
  localparam logic [7:0] CMD_PCT_THRESHOLDS = 8'hc6;

  // ----------------------------------------------------------------
  // fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RATED_FLOOR_VAL = 16'h0100;
  localparam logic [15:0] RATED_CEIL_VAL = 16'h0b01;
  localparam logic [7:0] BLOCK_COUNT_ONE = 8'h01;
  localparam logic [7:0] REACTION_RST = 8'h80;
  localparam logic [15:0] THRESHOLD_RST = 16'he340;
  localparam logic [15:0] PCT_RST = 16'h06e0;
  localparam logic [4:0] CURRENT_EXP = 5'h1c;
  localparam logic [2:0] RETRY_LATCH = 3'h0;
  localparam logic [2:0] RETRY_HICCUP = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EXP_LSB = 11;
  localparam int OVF_LSB = 9;
  localparam int OVW_LSB = 6;
  localparam int UVF_LSB = 3;

  // ----------------------------------------------------------------
  // timing: clock, delay windows (least edge), hiccup, averaging
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int DELAY_NS [8] = '{160000, 320000, 640000, 1280000,
                                  2560000, 5120000, 9600000, 10080000};
  localparam longint HICCUP_NS = 64'd1000000000;
  localparam int HICCUP_CYC = int'((HICCUP_NS + CLK_NS - 1) / CLK_NS);
  localparam int AVG_LOG2 = 4;
  localparam int AVG_SAMPLES = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] retry;
    logic [2:0] delay;
  } aoc_reaction_t;

  typedef struct packed {
    logic [3:0] unused_hi;
    logic [2:0] ov_fault;
    logic [2:0] ov_warn;
    logic [2:0] uv_fault;
    logic [2:0] unused_lo;
  } aoc_pct_t;

  typedef struct packed {
    aoc_reaction_t reaction;
    logic [15:0] threshold;
    aoc_pct_t pct;
  } aoc_nvm_image_t;

  typedef struct packed {
    logic status_iout;
    logic status_none;
    logic mfr_avg_bit7;
  } aoc_status_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_LIMIT = 3'b001,
    ST_LATCHED = 3'b010,
    ST_HICCUP = 3'b011,
    ST_OFF = 3'b100
  } aoc_state_t;

endpackage

`default_nettype wire

// ===== design/aoc_sync.sv
/*
  Per-bit pin synchroniser: four flip-flops, the output follows once
  the second and third stages agree.
  Assumes inputs asynchronous to core_clk_i.
*/
`default_nettype none

module aoc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,     // core clock
  input wire logic rst_i,          // sync reset, high
  input wire logic [W-1:0] d_i,    // raw pins
  output var logic [W-1:0] q_o     // filtered levels
);

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          q_o[g] <= 1'b0;
        end else begin
          s1 <= d_i[g];
          s2 <= s1;
          s3 <= s2;
          // only a settled level counts, one-cycle glitches are dropped
          if (s2 == s3) begin
            q_o[g] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== verif/aoc_checker.sv
/*
  Concurrent checks on the command port, status and store pulses.
  Assumes binding to aoc_regs on its own core clock and reset.
*/
`default_nettype none

module aoc_checker
  import aoc_pkg::*;
(
  input wire logic core_clk_i, // core clock
  input wire logic rst_i, // sync reset
  input wire logic cmd_valid_i, // command strobe
  input wire logic cmd_write_i, // write
  input wire logic cmd_block_i, // block framing
  input wire logic [7:0] cmd_code_i, // code
  input wire logic [15:0] cmd_wdata_i, // write word
  input wire logic store_all_i, // store pulse in
  input wire logic rsp_valid_o, // answer strobe
  input wire logic [15:0] rsp_data_o, // read word
  input wire logic rsp_nack_o, // refused
  input wire logic invalid_data_o, // invalid pulse
  input wire aoc_status_t status_o, // sticky status
  input wire logic host_alert_output_n_o, // alert, low
  input wire logic nvm_store_o // store pulse out
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------
  // sequences and properties
  // ---------------------------------
  sequence s_rd(logic [7:0] c, logic b);
    cmd_valid_i && !cmd_write_i && cmd_block_i == b && cmd_code_i == c;
  endsequence
  sequence s_wr(logic [7:0] c);
    cmd_valid_i && cmd_write_i && !cmd_block_i && cmd_code_i == c;
  endsequence
  sequence s_ok(logic [15:0] v);
    rsp_valid_o && !rsp_nack_o && rsp_data_o == v;
  endsequence
  sequence s_cnt;
    rsp_valid_o && !rsp_nack_o && rsp_data_o[7:0] == BLOCK_COUNT_ONE;
  endsequence
  sequence s_inv;
    rsp_valid_o && invalid_data_o && !rsp_nack_o;
  endsequence

  property p_answer;
    cmd_valid_i |=> rsp_valid_o;
  endproperty
  property p_quiet;
    !cmd_valid_i |=> !rsp_valid_o && !invalid_data_o;
  endproperty
  property p_floor;
    s_rd(CMD_RATED_FLOOR, 1'b0) |=> s_ok(RATED_FLOOR_VAL);
  endproperty
  property p_ceil;
    s_rd(CMD_RATED_CEIL, 1'b0) |=> s_ok(RATED_CEIL_VAL);
  endproperty
  property p_ident;
    s_rd(CMD_SI_IDENTITY, 1'b1) |=> s_cnt;
  endproperty
  property p_rev;
    s_rd(CMD_SI_REVISION, 1'b1) |=> s_cnt;
  endproperty
  property p_retry_bad;
    s_wr(CMD_AVG_REACTION) ##0 cmd_wdata_i[5:3] inside {[3'h1:3'h6]}
      |=> s_inv;
  endproperty
  property p_exp_bad;
    s_wr(CMD_AVG_THRESHOLD) ##0 cmd_wdata_i[15:11] != CURRENT_EXP
      |=> s_inv;
  endproperty
  property p_alert;
    (status_o == 3'b000 || status_o == 3'b111) &&
      ((status_o == 3'b111) == !host_alert_output_n_o);
  endproperty
  property p_store;
    nvm_store_o == $past(store_all_i);
  endproperty

  a_answer: assert property (p_answer)
    else $error("no answer");
  a_quiet: assert property (p_quiet)
    else $error("stray answer");
  a_floor: assert property (p_floor)
    else $error("floor word");
  a_ceil: assert property (p_ceil)
    else $error("ceiling word");
  a_ident: assert property (p_ident)
    else $error("identity count");
  a_rev: assert property (p_rev)
    else $error("revision count");
  a_retry_bad: assert property (p_retry_bad)
    else $error("bad retry unflagged");
  a_exp_bad: assert property (p_exp_bad)
    else $error("bad exponent unflagged");
  a_alert: assert property (p_alert)
    else $error("status vs alert");
  a_store: assert property (p_store)
    else $error("store pulse late");
endmodule

`default_nettype wire

// ===== verif/aoc_host_model.sv
/*
  Host model: presents decoded commands and collects the answer.
  Assumes the bench calls access() and shares the core clock.
*/
`default_nettype none

module aoc_host_model (
  input wire logic core_clk_i, // core clock
  input wire logic rsp_valid_i, // answer strobe
  input wire logic [15:0] rsp_data_i, // read word
  input wire logic rsp_nack_i, // refused
  input wire logic invalid_data_i, // invalid pulse
  output var logic cmd_valid_o, // command strobe
  output var logic cmd_write_o, // write
  output var logic cmd_block_o, // block framing
  output var logic [7:0] cmd_code_o, // code
  output var logic [15:0] cmd_wdata_o // write word
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_block_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end

  // answer stands one cycle; taken mid-cycle
  task automatic access(input logic w, b, input logic [7:0] c,
                        input logic [15:0] d, output logic [18:0] r);
    @(negedge core_clk_i);
    cmd_write_o = w;
    cmd_block_o = b;
    cmd_code_o = c;
    cmd_wdata_o = d;
    cmd_valid_o = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_o = 1'b0;
    cmd_wdata_o = ~d;
    r = {rsp_valid_i, invalid_data_i, rsp_nack_i, rsp_data_i};
  endtask
endmodule

`default_nettype wire

// ===== verif/testbench.sv
/*
  Self-checking bench for the average over-current registers.
  Assumes the host model and checker are compiled before it.
*/
`default_nettype none

module testbench;
  import aoc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] OK = 3'b100;
  localparam logic [2:0] INV = 3'b110;
  localparam logic [2:0] NAK = 3'b101;
  logic clk = 1'b0, rst = 1'b1, clr = 1'b0, clr_bit = 1'b0;
  logic store = 1'b0, smp = 1'b0, en = 1'b0, uv = 1'b0, lim = 1'b0;
  logic [10:0] iout = 11'h000, level = 11'h000;
  logic cv, cw, cb, rv_o, nack, inv, nvs, alert_n, cl, off;
  logic [7:0] cc;
  logic [15:0] cd, rdata, avg;
  aoc_status_t status;
  aoc_nvm_image_t img;
  aoc_pct_t pct;
  int mismatches = 0, check_count = 0;

  always #10 clk = ~clk;
  initial begin
    #7;
    forever #80 smp = ~smp;
  end
  // mantissa moves only while sample clock low
  always @(negedge clk) if (!smp) iout <= level;

  aoc_host_model u_host (.core_clk_i(clk), .rsp_valid_i(rv_o),
    .rsp_data_i(rdata), .rsp_nack_i(nack), .invalid_data_i(inv),
    .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_block_o(cb),
    .cmd_code_o(cc), .cmd_wdata_o(cd));

  aoc_regs #(.HICCUP_CYCLES(100)) u_dut (.core_clk_i(clk), .rst_i(rst),
    .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_block_i(cb),
    .cmd_code_i(cc), .cmd_wdata_i(cd), .clear_faults_i(clr),
    .clear_avg_bit_i(clr_bit), .store_all_i(store), .sample_clk_i(smp),
    .iout_mant_i(iout), .output_enable_i(en),
    .output_undervoltage_condition_i(uv), .limiting_i(lim),
    .rsp_valid_o(rv_o), .rsp_data_o(rdata), .rsp_nack_o(nack),
    .invalid_data_o(inv), .status_o(status),
    .host_alert_output_n_o(alert_n), .current_limit_o(cl),
    .output_off_o(off), .nvm_store_o(nvs), .nvm_image_o(img),
    .pct_o(pct), .avg_current_o(avg));

  // ---------------------------------
  // checking helpers
  // ---------------------------------
  task automatic chk(input logic [47:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic w, b, input logic [7:0] c,
                    input logic [15:0] d, input logic [18:0] e);
    logic [18:0] r;
    u_host.access(w, b, c, d, r);
    chk(48'(r), 48'(e));
  endtask
  function automatic logic [2:0] f_rea(input logic [7:0] v);
    return (v[5:3] == RETRY_LATCH || v[5:3] == RETRY_HICCUP) ? OK : INV;
  endfunction
  function automatic logic [2:0] f_lim(input logic [15:0] d);
    return (d[15:11] == CURRENT_EXP && d[10:0] != 11'h000) ? OK : INV;
  endfunction
  task automatic results;
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    results();
  end

  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    int i, n;
    logic [7:0] v, rea;
    logic [15:0] tv, pv;
    logic [15:0] lims [4];
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    void'($urandom(50107));
    rea = REACTION_RST;
    tv = THRESHOLD_RST;
    chk({status, alert_n, off}, 5'b00011);
    op(0, 0, CMD_AVG_REACTION, 0, {OK, 16'h0080});
    op(0, 0, CMD_AVG_THRESHOLD, 0, {OK, 16'he340});
    op(0, 0, CMD_PCT_THRESHOLDS, 0, {OK, 16'h06e0});
    op(0, 0, CMD_RATED_FLOOR, 0, {OK, 16'h0100});
    op(0, 0, CMD_RATED_CEIL, 0, {OK, 16'h0b01});
    op(0, 1, CMD_SI_IDENTITY, 0, {OK, 8'h5a, 8'h01});
    op(0, 1, CMD_SI_REVISION, 0, {OK, 8'h01, 8'h01});
    op(1, 0, CMD_RATED_FLOOR, 16'h1234, {NAK, 16'h0});
    op(1, 0, CMD_RATED_CEIL, 16'h0b01, {NAK, 16'h0});
    op(0, 0, CMD_SI_IDENTITY, 0, {NAK, 16'h0});
    op(0, 0, CMD_SI_REVISION, 0, {NAK, 16'h0});
    op(0, 1, CMD_RATED_FLOOR, 0, {NAK, 16'h0});
    for (i = 0; i < 8; i++) begin
      v = {2'($urandom), 3'(i), 3'(7 - i)};
      op(1, 0, CMD_AVG_REACTION, {8'h00, v}, {f_rea(v), 16'h0});
      if (f_rea(v) == OK) rea = v;
      op(0, 0, CMD_AVG_REACTION, 0, {OK, 8'h00, rea});
    end
    lims = '{{CURRENT_EXP, 11'h7ff}, {5'h1b, 11'h040},
             {CURRENT_EXP, 11'h000}, {CURRENT_EXP, 11'h001}};
    lims[3][10:0] = 11'($urandom_range(2047, 1));
    for (i = 0; i < 4; i++) begin
      op(1, 0, CMD_AVG_THRESHOLD, lims[i], {f_lim(lims[i]), 16'h0});
      if (f_lim(lims[i]) == OK) tv = lims[i];
      op(0, 0, CMD_AVG_THRESHOLD, 0, {OK, tv});
    end
    // fault level top, warning 2 to 7, undervoltage random, so both can equal it
    pv = {4'h0, 3'h7, 3'($urandom_range(7, 2)), 3'($urandom), 3'h0};
    op(1, 0, CMD_PCT_THRESHOLDS, pv, {OK, 16'h0});
    op(0, 0, CMD_PCT_THRESHOLDS, 0, {OK, pv});
    chk(pct, pv);
    store = 1'b1;
    @(negedge clk) chk({nvs, img}, {1'b1, rea, tv, pv});
    store = 1'b0;
    op(1, 0, CMD_AVG_THRESHOLD, {CURRENT_EXP, 11'd16}, {OK, 16'h0});
    op(1, 0, CMD_AVG_REACTION, 16'h00c0, {OK, 16'h0});
    en = 1'b1;
    for (n = 0; n < 50 && off !== 1'b0; n++) @(negedge clk);
    chk(off, 1'b0);
    level = 11'd40;
    for (n = 0; n < 600 && status === 3'b000; n++) @(negedge clk);
    chk({status, alert_n, cl}, 5'b11100);
    repeat (4) @(negedge clk);
    chk(off, 1'b1);
    level = 11'd0;
    repeat (300) @(negedge clk);
    chk({status, off, avg}, {4'b1111, CURRENT_EXP, 11'h000});
    clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    repeat (3) @(negedge clk);
    chk(status, 3'b000);
    for (n = 0; n < 50 && off !== 1'b0; n++) @(negedge clk);
    chk(off, 1'b0);
    op(1, 0, CMD_AVG_REACTION, 16'h00f8, {OK, 16'h0});
    level = 11'd40;
    for (n = 0; n < 600 && off !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 400 && off === 1'b1; n++) @(negedge clk);
    chk(48'(n >= 95 && n <= 110), 48'h1);
    level = 11'd0;
    repeat (300) @(negedge clk);
    clr_bit = 1'b1;
    @(negedge clk) clr_bit = 1'b0;
    repeat (3) @(negedge clk);
    chk({status, alert_n}, 4'b0001);
    results();
  end
endmodule

bind aoc_regs aoc_checker u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
  .cmd_block_i(cmd_block_i), .cmd_code_i(cmd_code_i),
  .cmd_wdata_i(cmd_wdata_i), .store_all_i(store_all_i),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
  .rsp_nack_o(rsp_nack_o), .invalid_data_o(invalid_data_o),
  .status_o(status_o), .host_alert_output_n_o(host_alert_output_n_o),
  .nvm_store_o(nvm_store_o));

`default_nettype wire
